/* utxp_core.sv */
// UART transmit path: APB registers, holding register or FIFO, and serialiser.
//
// Overview of operation
// - Eight-bit shifter loads from holding or FIFO.
// - Sixty-four byte FIFO behind the holding register.
// - Bit lasts 16, 8 or 4 ticks.
// - Start, data, optional parity, then stop bits.
// - Data bits leave least significant first.
// - Holding register is eight bits, write only.
// - FIFO control bit 0 routes writes into FIFO.
// - Each holding write in FIFO mode advances FIFO write pointer unless FIFO full.
// - Holding-empty sets when byte enters shifter.
// - Transmit-empty interrupt only while enable bit 1.
// - Transmitter-empty sets once shifter fully drained.
// - Divisor is high/low integer plus sixteenths.
// - Fraction bits 5:4 choose 16x, 8x, 4x.
// - Fraction low nibble gives sixteenths zero to fifteen.
// - Modem control bit 7 prescales by four.
// - In FIFO mode holding-empty means FIFO empty.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module utxp_core import utxp_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line and interrupt
   output logic txd,
   output logic tx_irq
);
   // Configuration registers
   logic [7:0] ien_q;
   logic [7:0] lctl_q;
   logic [7:0] mctl_q;
   logic [7:0] divl_q;
   logic [7:0] divh_q;
   logic [7:0] divf_q;
   logic fifo_en_q;

   // Non-FIFO holding byte
   logic [7:0] hold_q;
   logic hold_v_q;

   // Serialiser state
   utxp_state_t state_q;
   utxp_state_t state_d;
   logic [7:0] shifter_q;
   logic par_q;
   logic [4:0] tick_cnt_q;
   logic [2:0] bitn_q;
   logic txd_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // FIFO and baud generator connections
   logic [7:0] fifo_head;
   logic fifo_full;
   logic fifo_empty;
   logic [FIFO_AW:0] fifo_count;
   logic sample_tick;

   // Address decode
   wire hit_hold = paddr == OFF_HOLD;
   wire hit_ien = paddr == OFF_IEN;
   wire hit_istat = paddr == OFF_ISTAT;
   wire hit_fctl = paddr == OFF_FCTL;
   wire hit_lctl = paddr == OFF_LCTL;
   wire hit_mctl = paddr == OFF_MCTL;
   wire hit_lstat = paddr == OFF_LSTAT;
   wire hit_divl = paddr == OFF_DIVL;
   wire hit_divh = paddr == OFF_DIVH;
   wire hit_divf = paddr == OFF_DIVF;
   wire hit_level = paddr == OFF_LEVEL;
   wire mapped = hit_hold | hit_ien | hit_istat | hit_fctl | hit_lctl | hit_mctl |
                 hit_lstat | hit_divl | hit_divh | hit_divf | hit_level;
   wire setup_ph = psel & ~penable;
   wire wr_en = psel & penable & pwrite & mapped;

   wire wr_hold = wr_en & hit_hold;
   wire wr_fctl = wr_en & hit_fctl;
   // Changing mode or asking for a transmit reset flushes queued bytes
   wire fifo_clr = wr_fctl & (pwdata[FCTL_TX_RST] | (pwdata[FCTL_FIFO_EN] != fifo_en_q));

   // FIFO mode routes writes to FIFO
   wire fifo_push = wr_hold & fifo_en_q;

   // Frame configuration
   wire [1:0] os_sel = divf_q[DIVF_OS_LO +: 2];
   wire [1:0] wl_code = lctl_q[LCTL_WL_LO +: 2];
   wire [2:0] wl_last = {1'b1, wl_code};
   wire [1:0] wl_short = 2'h3 - wl_code;
   wire [7:0] data_mask = 8'hff >> wl_short;
   wire par_en = lctl_q[LCTL_PAR_EN];
   wire par_even = lctl_q[LCTL_PAR_EVEN];
   wire par_stick = lctl_q[LCTL_PAR_STICK];
   wire [2:0] stop_last = {2'b00, lctl_q[LCTL_STOP2]};

   // The tick runs free, so a start bit may lose up to one tick
   // bit length per oversampling mode
   // fraction bits 5:4 select the mode
   wire [4:0] bit_len = (os_sel == OS_8X) ? TICKS_8X : (os_sel == OS_4X) ? TICKS_4X : TICKS_16X;
   wire bit_end = sample_tick & (tick_cnt_q == bit_len - 5'h01);

   // shifter source is FIFO head or holding byte
   // FIFO head is the oldest entry
   wire can_load = fifo_en_q ? ~fifo_empty : hold_v_q;
   wire [7:0] src_byte = fifo_en_q ? fifo_head : hold_q;
   wire stop_done = (state_q == UTXP_STOP) & bit_end & (bitn_q == stop_last);
   // next byte starts straight after stop
   wire take = can_load & ((state_q == UTXP_IDLE) | stop_done);
   wire fifo_pop = take & fifo_en_q;

   wire [7:0] src_masked = src_byte & data_mask;
   wire par_calc = par_stick ? ~par_even : (par_even ? ^src_masked : ~^src_masked);

   // non-FIFO empty once byte moved to shifter
   // FIFO mode empty when FIFO holds nothing
   wire thr_empty = fifo_en_q ? fifo_empty : ~hold_v_q;
   // transmitter empty after the last stop bit
   wire tx_empty = thr_empty & (state_q == UTXP_IDLE);
   // interrupt gated by enable bit 1
   wire irq_d = thr_empty & ien_q[IEN_THRE];

   wire [7:0] lstat_val = {1'b0, tx_empty, thr_empty, 5'h00};
   wire [7:0] istat_val = {6'h00, irq_d, 1'b0};
   wire [31:0] rdata = hit_ien ? {24'h0, ien_q} :
                       hit_istat ? {24'h0, istat_val} :
                       hit_fctl ? {31'h0, fifo_en_q} :
                       hit_lctl ? {24'h0, lctl_q} :
                       hit_mctl ? {24'h0, mctl_q} :
                       hit_lstat ? {24'h0, lstat_val} :
                       hit_divl ? {24'h0, divl_q} :
                       hit_divh ? {24'h0, divh_q} :
                       hit_divf ? {24'h0, divf_q} :
                       hit_level ? {25'h0, fifo_count} : 32'h0;

   assign pready = psel & penable;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & psel & penable;
   assign txd = txd_q;
   assign tx_irq = irq_q;

   utxp_fifo u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .clr(fifo_clr),
      .push(fifo_push),
      .wdata(pwdata[7:0]),
      .pop(fifo_pop),
      .rdata(fifo_head),
      .full(fifo_full),
      .empty(fifo_empty),
      .count(fifo_count)
   );

   utxp_baud u_baud (
      .mclk(mclk),
      .rstn(rstn),
      .presc4(mctl_q[MCTL_PRESC]),
      .div_int({divh_q, divl_q}),
      .div_frac(divf_q[DIVF_FRAC_LO +: 4]),
      .sample_tick(sample_tick)
   );

   // Read data and error are captured in setup so they leave flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else if (setup_ph) begin
         prdata_q <= pwrite ? 32'h0 : rdata;
         pslverr_q <= ~mapped;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ien_q <= RST_IEN;
         lctl_q <= RST_LCTL;
         mctl_q <= RST_MCTL;
      end else begin
         if (wr_en & hit_ien) ien_q <= pwdata[7:0];
         if (wr_en & hit_lctl) lctl_q <= pwdata[7:0];
         if (wr_en & hit_mctl) mctl_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         divl_q <= RST_DIVL;
         divh_q <= RST_DIVH;
         divf_q <= RST_DIVF;
         fifo_en_q <= 1'b0;
      end else begin
         if (wr_en & hit_divl) divl_q <= pwdata[7:0];
         if (wr_en & hit_divh) divh_q <= pwdata[7:0];
         if (wr_en & hit_divf) divf_q <= pwdata[7:0];
         if (wr_fctl) fifo_en_q <= pwdata[FCTL_FIFO_EN];
      end
   end

   // a second write before the load replaces the byte
   // A write in the load cycle wins, so the new byte is not lost
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hold_q <= '0;
         hold_v_q <= 1'b0;
      end else begin
         if (wr_hold & ~fifo_en_q) begin
            hold_q <= pwdata[7:0];
            hold_v_q <= 1'b1;
         end else if (fifo_clr | (take & ~fifo_en_q)) begin
            hold_v_q <= 1'b0;
         end
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         UTXP_IDLE: begin
            if (can_load) state_d = UTXP_START;
         end
         UTXP_START: begin
            if (bit_end) state_d = UTXP_DATA;
         end
         UTXP_DATA: begin
            if (bit_end & (bitn_q == wl_last)) state_d = par_en ? UTXP_PAR : UTXP_STOP;
         end
         UTXP_PAR: begin
            if (bit_end) state_d = UTXP_STOP;
         end
         UTXP_STOP: begin
            if (stop_done) state_d = can_load ? UTXP_START : UTXP_IDLE;
         end
         default: begin
            state_d = UTXP_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= UTXP_IDLE;
         tick_cnt_q <= '0;
         bitn_q <= '0;
      end else begin
         state_q <= state_d;
         if (take | bit_end) tick_cnt_q <= '0;
         else if (sample_tick) tick_cnt_q <= tick_cnt_q + 5'h01;
         if (take | (bit_end & (state_d != state_q))) bitn_q <= '0;
         else if (bit_end) bitn_q <= bitn_q + 3'h1;
      end
   end

   // shift right so bit 0 leaves first
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shifter_q <= '0;
         par_q <= 1'b0;
      end else if (take) begin
         shifter_q <= src_byte;
         par_q <= par_calc;
      end else if ((state_q == UTXP_DATA) & bit_end) begin
         shifter_q <= {1'b0, shifter_q[7:1]};
      end
   end

   // Break holds the line low whatever the serialiser is doing
   // line high when idle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         txd_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         if (lctl_q[LCTL_BREAK]) txd_q <= 1'b0;
         else if (state_q == UTXP_START) txd_q <= 1'b0;
         else if (state_q == UTXP_DATA) txd_q <= shifter_q[0];
         else if (state_q == UTXP_PAR) txd_q <= par_q;
         else txd_q <= 1'b1;
      end
   end
endmodule

/* utxp_pkg.sv */
// Shared constants and types for the UART transmit path.
package utxp_pkg;

   // Register byte offsets on the APB (one aligned word each)
   localparam logic [7:0] OFF_HOLD = 8'h00;
   localparam logic [7:0] OFF_IEN = 8'h04;
   localparam logic [7:0] OFF_ISTAT = 8'h08;
   localparam logic [7:0] OFF_FCTL = 8'h0c;
   localparam logic [7:0] OFF_LCTL = 8'h10;
   localparam logic [7:0] OFF_MCTL = 8'h14;
   localparam logic [7:0] OFF_LSTAT = 8'h18;
   localparam logic [7:0] OFF_DIVL = 8'h1c;
   localparam logic [7:0] OFF_DIVH = 8'h20;
   localparam logic [7:0] OFF_DIVF = 8'h24;
   localparam logic [7:0] OFF_LEVEL = 8'h28;

   // Field positions
   localparam int FCTL_FIFO_EN = 0;
   localparam int FCTL_TX_RST = 2;
   localparam int IEN_THRE = 1;
   localparam int ISTAT_THRE = 1;
   localparam int LSTAT_THRE = 5;
   localparam int LSTAT_TEMT = 6;
   localparam int MCTL_PRESC = 7;
   localparam int LCTL_WL_LO = 0;
   localparam int LCTL_STOP2 = 2;
   localparam int LCTL_PAR_EN = 3;
   localparam int LCTL_PAR_EVEN = 4;
   localparam int LCTL_PAR_STICK = 5;
   localparam int LCTL_BREAK = 6;
   localparam int DIVF_FRAC_LO = 0;
   localparam int DIVF_OS_LO = 4;

   // Reset values
   localparam logic [7:0] RST_DIVL = 8'h01;
   localparam logic [7:0] RST_DIVH = 8'h00;
   localparam logic [7:0] RST_DIVF = 8'h00;
   localparam logic [7:0] RST_LCTL = 8'h03;
   localparam logic [7:0] RST_IEN = 8'h00;
   localparam logic [7:0] RST_MCTL = 8'h00;

   // Oversampling codes and sampling-clock periods per bit
   localparam logic [1:0] OS_16X = 2'b00;
   localparam logic [1:0] OS_8X = 2'b01;
   localparam logic [1:0] OS_4X = 2'b10;
   localparam logic [4:0] TICKS_16X = 5'h10;
   localparam logic [4:0] TICKS_8X = 5'h08;
   localparam logic [4:0] TICKS_4X = 5'h04;

   // Baud generator: prescaler last count (divide by 4), one whole in sixteenths
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [20:0] FRAC_ONE = 21'h00010;

   // Transmit FIFO
   localparam int FIFO_DEPTH = 64;
   localparam int FIFO_AW = 6;

   typedef enum logic [2:0] {
      UTXP_IDLE = 3'b000,
      UTXP_START = 3'b001,
      UTXP_DATA = 3'b010,
      UTXP_PAR = 3'b011,
      UTXP_STOP = 3'b100
   } utxp_state_t;

endpackage

/* utxp_fifo.sv */
// Transmit FIFO of byte entries with flush, level and full/empty flags.
`timescale 1ns/1ps
module utxp_fifo import utxp_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Control
   input wire logic clr,
   input wire logic push,
   input wire logic [7:0] wdata,
   input wire logic pop,
   // Head and state
   output logic [7:0] rdata,
   output logic full,
   output logic empty,
   output logic [FIFO_AW:0] count
);
   logic [7:0] mem [0:FIFO_DEPTH-1];
   logic [FIFO_AW-1:0] wr_q;
   logic [FIFO_AW-1:0] rd_q;
   logic [FIFO_AW:0] cnt_q;

   // Pushes into a full FIFO are dropped so queued bytes stay intact
   wire do_push = push & ~full;
   wire do_pop = pop & ~empty;

   assign full = cnt_q == FIFO_DEPTH[FIFO_AW:0];
   assign empty = cnt_q == '0;
   assign count = cnt_q;
   assign rdata = mem[rd_q];

   always_ff @(posedge mclk) begin
      if (do_push) begin
         mem[wr_q] <= wdata;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (clr) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_q + FIFO_AW'(do_push);
         rd_q <= rd_q + FIFO_AW'(do_pop);
         cnt_q <= cnt_q + (FIFO_AW + 1)'(do_push) - (FIFO_AW + 1)'(do_pop);
      end
   end
endmodule

/* utxp_baud.sv */
// Prescaler and fractional baud divisor producing the sampling-clock tick.
`timescale 1ns/1ps
module utxp_baud import utxp_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Configuration
   input wire logic presc4,
   input wire logic [15:0] div_int,
   input wire logic [3:0] div_frac,
   // Sampling clock, one cycle per period
   output logic sample_tick
);
   logic [1:0] pre_q;
   logic [20:0] acc_q;
   logic tick_q;

   // Divisor in sixteenths; below one it is treated as one
   wire [20:0] div16_raw = {1'b0, div_int, div_frac};
   wire [20:0] div16 = (div16_raw < FRAC_ONE) ? FRAC_ONE : div16_raw;
   wire pre_en = presc4 ? (pre_q == PRESC_LAST) : 1'b1;
   wire [20:0] acc_sum = acc_q + FRAC_ONE;
   wire acc_wrap = acc_sum >= div16;

   assign sample_tick = tick_q;

   // Accumulating sixteenths spreads the fraction as small period jitter
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pre_q <= '0;
         acc_q <= '0;
         tick_q <= 1'b0;
      end else begin
         pre_q <= pre_q + 2'h1;
         tick_q <= pre_en & acc_wrap;
         if (pre_en) begin
            acc_q <= acc_wrap ? acc_sum - div16 : acc_sum;
         end
      end
   end
endmodule

/* utxp_core_checker.sv */
// Concurrent checks on the transmit path's ports.
`timescale 1ns/1ps
module utxp_core_checker import utxp_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Serial line and interrupt
   input wire logic txd,
   input wire logic tx_irq
);
   logic ien_q;
   wire acc = psel & penable;
   wire rd = acc & ~pwrite;
   wire unmapped = (paddr > OFF_LEVEL) | (paddr[1:0] != 2'b00);

   // Shadow of the interrupt enable, so the gate can be judged
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ien_q <= 1'b0;
      end else if (acc && pwrite && paddr == OFF_IEN) begin
         ien_q <= pwdata[IEN_THRE];
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   property p_unmapped_err; acc && unmapped |-> pslverr; endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("no error on unmapped");
   property p_unmapped_zero; rd && unmapped |-> prdata == 32'h0; endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_upper_zero; rd |-> prdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_irq_gate; !ien_q && !$past(ien_q) |-> !tx_irq; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
   property p_idle_reset; $rose(rstn) |-> txd [*4]; endproperty
   a_idle_reset: assert property (p_idle_reset) else $error("line not idle high");
   // Shortest legal bit is 4 ticks, start may lose one
   property p_min_bit; $changed(txd) |=> $stable(txd) [*2]; endproperty
   a_min_bit: assert property (p_min_bit) else $error("bit too short");
   property p_level_max; rd && paddr == OFF_LEVEL |-> prdata[7:0] <= 8'h40; endproperty
   a_level_max: assert property (p_level_max) else $error("level above depth");
   property p_fctl_read; rd && paddr == OFF_FCTL |-> prdata[7:1] == 7'h0; endproperty
   a_fctl_read: assert property (p_fctl_read) else $error("fifo control readback");

   cover property (acc && pwrite && paddr == OFF_HOLD);
   cover property ($fell(txd));
   cover property ($rose(tx_irq));
endmodule

bind utxp_core utxp_core_checker utxp_core_checker_inst (.mclk(mclk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .txd(txd), .tx_irq(tx_irq));

/* utxp_rx_model.sv */
// Remote serial receiver that decodes frames from the line.
`timescale 1ns/1ps
module utxp_rx_model (
   // Clock and line
   input wire logic mclk,
   input wire logic txd,
   // Frame shape
   input int bit_cyc,
   input wire logic par_en
);
   logic [9:0] got[$];
   int starts[$];
   int cyc = 0;

   always @(posedge mclk) begin
      cyc <= cyc + 1;
   end

   // Samples mid-bit, so a start shortened by one tick still decodes
   initial begin
      logic [9:0] f;
      int n;
      forever begin
         @(negedge txd);
         starts.push_back(cyc);
         n = par_en ? 9 : 8;
         f = 10'h0;
         repeat (bit_cyc / 2) @(posedge mclk);
         for (int i = 0; i < n; i++) begin
            repeat (bit_cyc) @(posedge mclk);
            f[i] = txd;
         end
         repeat (bit_cyc) @(posedge mclk);
         f[9] = txd;
         got.push_back(f);
      end
   end
endmodule

/* tb_top.sv */
// Self-checking bench for the UART transmit path.
`timescale 1ns/1ps
module tb_top import utxp_pkg::*;;
   logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, par_en = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic pready, pslverr, txd, tx_irq, err_q;
   int errors = 0, checks = 0, bit_cyc = 16, cyc = 0;

   always #4 mclk = ~mclk;

   utxp_core utxp_core_inst (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .txd(txd), .tx_irq(tx_irq));
   utxp_rx_model utxp_rx_model_inst (.mclk(mclk), .txd(txd), .bit_cyc(bit_cyc), .par_en(par_en));

   task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(string n, logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hffffffff);
      apb(1'b0, a, 32'h0);
      chk(n, rd_q & m, e);
   endtask

   task automatic frame(logic [7:0] b, logic p);
      while (utxp_rx_model_inst.got.size() == 0) @(posedge mclk);
      chk("frame", {22'h0, utxp_rx_model_inst.got.pop_front()}, {22'h0, 1'b1, p, b});
   endtask

   task automatic gap_chk(int i);
      int d;
      d = utxp_rx_model_inst.starts[i + 1] - utxp_rx_model_inst.starts[i];
      chk("gap", d inside {[10 * bit_cyc - 8 : 10 * bit_cyc + 1]}, 1);
   endtask

   task automatic t_reset();
      rchk("divl", OFF_DIVL, 32'h1);
      rchk("divh", OFF_DIVH, 32'h0);
      rchk("divf", OFF_DIVF, 32'h0);
      rchk("mctl", OFF_MCTL, 32'h0);
      rchk("lctl", OFF_LCTL, 32'h3);
      rchk("ien", OFF_IEN, 32'h0);
      rchk("fctl", OFF_FCTL, 32'h0);
      rchk("level", OFF_LEVEL, 32'h0);
      chk("irq", tx_irq, 0);
      rchk("lstat", OFF_LSTAT, 32'h60, 32'h60);
      apb(1'b0, 8'h2c, 32'h0);
      chk("slverr", err_q, 1);
   endtask

   task automatic t_frame();
      utxp_rx_model_inst.starts.delete();
      wr(OFF_HOLD, 32'h1a5);
      rchk("lstat", OFF_LSTAT, 32'h20, 32'h60);
      wr(OFF_HOLD, 32'h3c);
      frame(8'ha5, 1'b0);
      frame(8'h3c, 1'b0);
      gap_chk(0);
      repeat (bit_cyc) @(posedge mclk);
      rchk("lstat", OFF_LSTAT, 32'h60, 32'h60);
   endtask

   task automatic t_modes();
      int cfg[4][4] = '{'{16, 0, 1, 8}, '{32, 0, 1, 4}, '{8, 0, 2, 40}, '{0, 128, 1, 64}};
      for (int i = 0; i < 4; i++) begin
         wr(OFF_DIVF, cfg[i][0]);
         wr(OFF_MCTL, cfg[i][1]);
         wr(OFF_DIVL, cfg[i][2]);
         bit_cyc = cfg[i][3];
         wr(OFF_HOLD, 32'h5a + i);
         frame(8'h5a + 8'(i), 1'b0);
         repeat (bit_cyc) @(posedge mclk);
      end
      wr(OFF_MCTL, 32'h0);
      wr(OFF_DIVF, 32'h0);
      wr(OFF_DIVL, 32'h1);
      bit_cyc = 16;
   endtask

   task automatic t_parity();
      wr(OFF_LCTL, 32'h1b);
      par_en = 1'b1;
      wr(OFF_HOLD, 32'h07);
      frame(8'h07, 1'b1);
      par_en = 1'b0;
      repeat (bit_cyc) @(posedge mclk);
      // Seven bits with odd parity: the parity lands in the eighth slot
      wr(OFF_LCTL, 32'h0a);
      wr(OFF_HOLD, 32'hff);
      frame(8'h7f, 1'b0);
      repeat (bit_cyc) @(posedge mclk);
      wr(OFF_LCTL, 32'h03);
   endtask

   task automatic t_shape();
      // Five bits, odd parity, two stops: parity and stops fill slots 5 to 7
      wr(OFF_LCTL, 32'h0c);
      wr(OFF_HOLD, 32'h03);
      frame(8'he3, 1'b0);
      repeat (bit_cyc) @(posedge mclk);
      // Stick parity sends a one where odd parity would send zero
      wr(OFF_LCTL, 32'h2b);
      par_en = 1'b1;
      wr(OFF_HOLD, 32'h01);
      frame(8'h01, 1'b1);
      par_en = 1'b0;
      repeat (bit_cyc) @(posedge mclk);
      wr(OFF_LCTL, 32'h07);
      utxp_rx_model_inst.starts.delete();
      wr(OFF_HOLD, 32'h81);
      wr(OFF_HOLD, 32'h42);
      frame(8'h81, 1'b0);
      frame(8'h42, 1'b0);
      chk("gap2", utxp_rx_model_inst.starts[1] - utxp_rx_model_inst.starts[0], 11 * bit_cyc);
      repeat (2 * bit_cyc) @(posedge mclk);
      wr(OFF_LCTL, 32'h03);
   endtask

   task automatic t_fifo();
      wr(OFF_DIVL, 32'h4);
      bit_cyc = 64;
      wr(OFF_FCTL, 32'h1);
      wr(OFF_IEN, 32'h2);
      utxp_rx_model_inst.starts.delete();
      for (int i = 0; i < 70; i++) begin
         wr(OFF_HOLD, i);
      end
      rchk("level", OFF_LEVEL, 32'h40);
      rchk("lstat", OFF_LSTAT, 32'h0, 32'h20);
      chk("irq", tx_irq, 0);
      for (int i = 0; i < 65; i++) begin
         frame(8'(i), 1'b0);
      end
      for (int i = 0; i < 64; i++) begin
         gap_chk(i);
      end
      repeat (bit_cyc) @(posedge mclk);
      rchk("lstat", OFF_LSTAT, 32'h60, 32'h60);
      rchk("istat", OFF_ISTAT, 32'h2, 32'h2);
      chk("irq", tx_irq, 1);
      wr(OFF_IEN, 32'h0);
      rchk("istat", OFF_ISTAT, 32'h0, 32'h2);
      chk("irq", tx_irq, 0);
      // Flush drops queued bytes; the byte already in the shifter still leaves
      wr(OFF_HOLD, 32'h11);
      wr(OFF_HOLD, 32'h22);
      wr(OFF_HOLD, 32'h33);
      rchk("level", OFF_LEVEL, 32'h2);
      rchk("fctl", OFF_FCTL, 32'h1);
      wr(OFF_FCTL, 32'h5);
      rchk("level", OFF_LEVEL, 32'h0);
      frame(8'h11, 1'b0);
      repeat (12 * bit_cyc) @(posedge mclk);
      chk("flushed", utxp_rx_model_inst.got.size(), 0);
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_frame();
      t_modes();
      t_parity();
      t_shape();
      t_fifo();
      give_verdict();
   end
endmodule
